// file: csvt_params.svh
// Offsets, field positions, reset values and timing counts of the video transmitter
`ifndef CSVT_PARAMS_SVH
`define CSVT_PARAMS_SVH

`define CSVT_ADR_CTRL 8'h00
`define CSVT_ADR_STATUS 8'h04
`define CSVT_ADR_FRAMES 8'h08

`define CSVT_CTRL_LANES_LSB 0
`define CSVT_CTRL_FMODE_BIT 2
`define CSVT_CTRL_CONT_BIT 3
`define CSVT_CTRL_EN_BIT 4
`define CSVT_CTRL_RESET 5'h13

`define CSVT_STAT_BUSY_BIT 0
`define CSVT_STAT_ULPS_LSB 1
`define CSVT_STAT_REF_BIT 6
`define CSVT_STAT_ESC_BIT 7
`define CSVT_STAT_CONFLICT_BIT 8
`define CSVT_STAT_DROP_BIT 9

`define CSVT_CLK_MHZ 100
`define CSVT_ULPS_PULSE_US 5
`define CSVT_ULPS_CYCLES (`CSVT_ULPS_PULSE_US * `CSVT_CLK_MHZ)
`define CSVT_ALIVE_CYCLES 32

`define CSVT_DT_FS 6'h00
`define CSVT_DT_FE 6'h01
`define CSVT_DT_LS 6'h02
`define CSVT_DT_LE 6'h03
`define CSVT_CRC_INIT 16'hFFFF
`define CSVT_CRC_POLY 16'h8408

`endif

// file: csvt_pkg.sv
// Types shared by the video transmitter modules
package csvt_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HDR = 5'h02,
    ST_PAY = 5'h04,
    ST_CRC = 5'h08,
    ST_TRAIL = 5'h10
  } csvt_state_t;

  typedef struct packed {
    logic en;
    logic cont_clk;
    logic frame_mode;
    logic [1:0] lanes;
  } csvt_cfg_t;

  typedef struct packed {
    logic pclk;
    logic vsync;
    logic hsync;
    logic valid;
    logic [15:0] line_width;
    logic [63:0] data;
    logic [5:0] dtype;
    logic [1:0] vc;
    logic [4:0] sleep;
    logic [4:0] wake;
    logic ref_clk;
    logic escape_clock;
    logic phy_rst_n;
    logic ctl_rst_n;
  } csvt_pin_t;

endpackage

// file: csvt_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module csvt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [WIDTH-1:0] ASYNC_IN,
  output logic [WIDTH-1:0] SYNC_OUT
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      meta_q <= '0;
      SYNC_OUT <= '0;
    end else begin
      meta_q <= ASYNC_IN;
      SYNC_OUT <= meta_q;
    end
  end
endmodule

// file: csvt_transmitter.sv
// Camera-serial video transmitter: pixel capture, packetiser, lane distribution, sleep control, Wishbone regs
`timescale 1ns/1ps
`include "csvt_params.svh"

// Functional notes
// - Packets follow camera serial protocol 1.3 and physical layer 1.1 byte framing.
// - Four data lanes and one clock lane are driven toward the board.
// - Lane count 00 one, 01 two, 11 four lanes; latched only in reset.
// - Lanes run high-speed up to 1.5 Gbps each in the physical layer.
// - Clock lane runs continuous or only around packets, as selected.
// - Only protocol packets reach the lanes; no raw lane access exists.
// - Physical-layer and controller resets are active low, normally together.
// - Transmit PLL takes one shared dedicated reference clock input.
// - A new 64-bit pixel word is captured on each pixel clock that has pixel valid high inside a line.
// - Frame mode 0 general, 1 accurate; changed only during reset.
// - Held clock-lane sleep or wake pulse moves clock lane; both together ignored.
// - Held per-lane sleep or wake pulse moves data lanes; both together ignored.
// - Raw, RGB, YUV420, YUV422 and user 8-bit types are supported.
module csvt_transmitter #(
  parameter int ULPS_CYCLES = `CSVT_ULPS_CYCLES,
  parameter int ALIVE_CYCLES = `CSVT_ALIVE_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic SHARED_REFERENCE_PIN_IN,
  input wire logic PIXEL_CLK_IN,
  input wire logic ESCAPE_CLOCK_IN,
  input wire logic PHY_RESET_N_IN,
  input wire logic CONTROLLER_RESET_N_IN,
  input wire logic VSYNC_IN,
  input wire logic HSYNC_IN,
  input wire logic PIXEL_VALID_IN,
  input wire logic [15:0] LINE_WIDTH_IN,
  input wire logic [63:0] PIXEL_DATA_IN,
  input wire logic [5:0] DATA_TYPE_IN,
  input wire logic [1:0] VIRTUAL_CHANNEL_ID_IN,
  input wire logic CLOCK_LANE_SLEEP_REQUEST_IN,
  input wire logic CLOCK_LANE_WAKE_REQUEST_IN,
  input wire logic [3:0] DATA_LANE_SLEEP_REQUEST_IN,
  input wire logic [3:0] DATA_LANE_WAKE_REQUEST_IN,
  output logic [31:0] LANE_BYTE_OUT,
  output logic [3:0] LANE_BYTE_VALID_OUT,
  output logic [3:0] DATA_LANE_HS_OUT,
  output logic CLOCK_LANE_HS_OUT,
  output logic [3:0] DATA_LANE_ULPS_OUT,
  output logic CLOCK_LANE_ULPS_OUT
);

  if (ULPS_CYCLES < 1 || ULPS_CYCLES > 65535) begin : g_bad_ulps
    $error("ULPS_CYCLES out of range");
  end
  if (ALIVE_CYCLES < 2 || ALIVE_CYCLES > 255) begin : g_bad_alive
    $error("ALIVE_CYCLES out of range");
  end

  csvt_pkg::csvt_pin_t pin_raw;
  csvt_pkg::csvt_pin_t pin;
  csvt_pkg::csvt_cfg_t ctrl_q;
  csvt_pkg::csvt_cfg_t cfg_q;
  csvt_pkg::csvt_state_t state_q;

  logic pclk_prev_q, vs_prev_q, hs_prev_q;
  logic pix_tick, vs_rise, vs_fall, hs_rise, hs_fall;
  logic [4:0] pend_q, pend_set, pick;
  logic go;
  logic [1:0] vc_q;
  logic [15:0] width_q, wc_q, frame_num_q, line_num_q, pay_cnt_q;
  logic [31:0] hdr_q;
  logic [1:0] hdr_cnt_q;
  logic is_long_q, crc_cnt_q;
  logic [15:0] crc_q;
  logic [63:0] word_q;
  logic [3:0] word_bytes_q;
  logic in_line_q, line_done_q, drop_q, conflict_q;
  logic emit_v, pay_take;
  logic [7:0] emit_b;
  logic [1:0] lane_idx_q;
  logic [3:0] lane_mask;
  logic [4:0] ulps_q, conflict_now;
  logic [1:0] alive_q;
  logic wb_req, wb_wr_status;
  logic [5:0] sel_dt;

  assign pin_raw = '{pclk: PIXEL_CLK_IN, vsync: VSYNC_IN, hsync: HSYNC_IN, valid: PIXEL_VALID_IN,
                     line_width: LINE_WIDTH_IN, data: PIXEL_DATA_IN, dtype: DATA_TYPE_IN,
                     vc: VIRTUAL_CHANNEL_ID_IN,
                     sleep: {CLOCK_LANE_SLEEP_REQUEST_IN, DATA_LANE_SLEEP_REQUEST_IN},
                     wake: {CLOCK_LANE_WAKE_REQUEST_IN, DATA_LANE_WAKE_REQUEST_IN},
                     ref_clk: SHARED_REFERENCE_PIN_IN, escape_clock: ESCAPE_CLOCK_IN,
                     phy_rst_n: PHY_RESET_N_IN, ctl_rst_n: CONTROLLER_RESET_N_IN};

  csvt_sync #(.WIDTH($bits(csvt_pkg::csvt_pin_t))) u_sync (
    .CLK_IN(CLK_IN),
    .RESET_N_IN(RESET_N_IN),
    .ASYNC_IN(pin_raw),
    .SYNC_OUT(pin)
  );

  // 6-bit header ECC over the 24 header bits
  function automatic logic [7:0] hdr_ecc(input logic [23:0] d);
    hdr_ecc = {2'b00, ^(d & 24'hEFFC00), ^(d & 24'hDF03F0), ^(d & 24'hB8E38E),
               ^(d & 24'h749A6D), ^(d & 24'hF2555B), ^(d & 24'hF12CB7)};
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `CSVT_CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  function automatic logic [4:0] type_bpp(input logic [5:0] t);
    unique case (t)
      6'h20, 6'h2C: type_bpp = 5'h0C;
      6'h21: type_bpp = 5'h0F;
      6'h22, 6'h1E: type_bpp = 5'h10;
      6'h23: type_bpp = 5'h12;
      6'h24: type_bpp = 5'h18;
      6'h28: type_bpp = 5'h06;
      6'h29: type_bpp = 5'h07;
      6'h2B, 6'h19, 6'h1D: type_bpp = 5'h0A;
      6'h2D: type_bpp = 5'h0E;
      6'h1F: type_bpp = 5'h14;
      default: type_bpp = 5'h08;
    endcase
  endfunction

  // Pixel inputs are taken on the falling pixel-clock edge, mid-period, after data has settled
  assign pix_tick = pclk_prev_q & ~pin.pclk;
  assign vs_rise = pix_tick & pin.vsync & ~vs_prev_q;
  assign vs_fall = pix_tick & ~pin.vsync & vs_prev_q;
  assign hs_rise = pix_tick & pin.hsync & ~hs_prev_q;
  assign hs_fall = pix_tick & ~pin.hsync & hs_prev_q;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pclk_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
      hs_prev_q <= 1'b0;
    end else begin
      pclk_prev_q <= pin.pclk;
      if (pix_tick) begin
        vs_prev_q <= pin.vsync;
        hs_prev_q <= pin.hsync;
      end
    end
  end

  // Lane count and frame mode only follow software while the controller is held in reset
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cfg_q <= `CSVT_CTRL_RESET;
    end else if (!pin.ctl_rst_n) begin
      cfg_q <= ctrl_q;
    end else begin
      cfg_q.en <= ctrl_q.en;
    end
  end

  always_comb begin
    unique case (cfg_q.lanes)
      2'b00: lane_mask = 4'h1;
      2'b01: lane_mask = 4'h3;
      default: lane_mask = 4'hF;
    endcase
  end

  // Frame-level values are latched at the sync edges, so mid-frame changes cannot tear a packet
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      vc_q <= 2'h0;
      width_q <= 16'h0000;
      wc_q <= 16'h0000;
      frame_num_q <= 16'h0000;
      line_num_q <= 16'h0000;
    end else if (!pin.ctl_rst_n) begin
      frame_num_q <= 16'h0000;
      line_num_q <= 16'h0000;
    end else begin
      if (vs_rise) begin
        vc_q <= pin.vc;
        width_q <= pin.line_width;
        frame_num_q <= frame_num_q + 16'h0001;
        line_num_q <= 16'h0000;
      end
      if (hs_rise) begin
        wc_q <= 16'((32'(width_q) * 32'(type_bpp(pin.dtype))) >> 3);
        line_num_q <= line_num_q + 16'h0001;
      end
    end
  end

  // Pending packets, bit order is priority: FS, LS, long, LE, FE
  assign pend_set = {vs_fall, hs_fall & cfg_q.frame_mode, hs_rise, hs_rise & cfg_q.frame_mode, vs_rise};
  assign go = (state_q == csvt_pkg::ST_IDLE) && cfg_q.en && pin.phy_rst_n && ((ulps_q[3:0] & lane_mask) == 4'h0)
              && !ulps_q[4];
  assign pick = go ? (pend_q & 5'(~pend_q + 5'h01)) : 5'h00;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pend_q <= 5'h00;
    end else if (!pin.ctl_rst_n) begin
      pend_q <= 5'h00;
    end else begin
      pend_q <= (pend_q & ~pick) | pend_set;
    end
  end

  always_comb begin
    unique case (1'b1)
      pick[0]: sel_dt = `CSVT_DT_FS;
      pick[1]: sel_dt = `CSVT_DT_LS;
      pick[3]: sel_dt = `CSVT_DT_LE;
      pick[4]: sel_dt = `CSVT_DT_FE;
      default: sel_dt = pin.dtype;
    endcase
  end

  // Line-level words; a word not fully sent when the next arrives is replaced and flagged
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      word_q <= 64'h0;
      word_bytes_q <= 4'h0;
      in_line_q <= 1'b0;
      line_done_q <= 1'b0;
    end else if (!pin.ctl_rst_n) begin
      word_bytes_q <= 4'h0;
      in_line_q <= 1'b0;
      line_done_q <= 1'b0;
    end else begin
      if (hs_rise) begin
        in_line_q <= 1'b1;
      end else if (hs_fall) begin
        in_line_q <= 1'b0;
      end
      if (hs_fall) begin
        line_done_q <= 1'b1;
      end else if (pick[2]) begin
        line_done_q <= 1'b0;
      end
      if (pix_tick && pin.valid && (in_line_q || hs_rise)) begin
        word_q <= pin.data;
        word_bytes_q <= 4'h8;
      end else if (pay_take) begin
        word_q <= word_q >> 8;
        word_bytes_q <= word_bytes_q - 4'h1;
      end else if (state_q == csvt_pkg::ST_TRAIL && !is_long_q) begin
        word_bytes_q <= word_bytes_q;
      end
    end
  end

  always_comb begin
    emit_v = 1'b0;
    emit_b = 8'h00;
    pay_take = 1'b0;
    unique case (state_q)
      csvt_pkg::ST_HDR: begin
        emit_v = 1'b1;
        emit_b = hdr_q[7:0];
      end
      csvt_pkg::ST_PAY: begin
        if (word_bytes_q != 4'h0) begin
          emit_v = 1'b1;
          emit_b = word_q[7:0];
          pay_take = 1'b1;
        end else if (line_done_q) begin
          emit_v = 1'b1;
        end
      end
      csvt_pkg::ST_CRC: begin
        emit_v = 1'b1;
        emit_b = crc_cnt_q ? crc_q[15:8] : crc_q[7:0];
      end
      csvt_pkg::ST_IDLE, csvt_pkg::ST_TRAIL: begin
      end
    endcase
  end

  // Packet sequencer; there is no path that puts non-packet bytes on the lanes
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= csvt_pkg::ST_IDLE;
      hdr_q <= 32'h0;
      hdr_cnt_q <= 2'h0;
      is_long_q <= 1'b0;
      pay_cnt_q <= 16'h0000;
      crc_q <= `CSVT_CRC_INIT;
      crc_cnt_q <= 1'b0;
    end else if (!pin.ctl_rst_n) begin
      state_q <= csvt_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        csvt_pkg::ST_IDLE: begin
          if (pick != 5'h00) begin
            hdr_q[23:0] <= {pick[2] ? wc_q : (pick[0] | pick[4]) ? frame_num_q : line_num_q, vc_q, sel_dt};
            hdr_q[31:24] <= hdr_ecc({pick[2] ? wc_q : (pick[0] | pick[4]) ? frame_num_q : line_num_q,
                                     vc_q, sel_dt});
            is_long_q <= pick[2];
            hdr_cnt_q <= 2'h0;
            state_q <= csvt_pkg::ST_HDR;
          end
        end
        csvt_pkg::ST_HDR: begin
          hdr_q <= hdr_q >> 8;
          hdr_cnt_q <= hdr_cnt_q + 2'h1;
          pay_cnt_q <= 16'h0000;
          crc_q <= `CSVT_CRC_INIT;
          crc_cnt_q <= 1'b0;
          if (hdr_cnt_q == 2'h3) begin
            state_q <= (is_long_q && wc_q != 16'h0000) ? csvt_pkg::ST_PAY :
                       is_long_q ? csvt_pkg::ST_CRC : csvt_pkg::ST_TRAIL;
          end
        end
        csvt_pkg::ST_PAY: begin
          if (emit_v) begin
            crc_q <= crc_byte(crc_q, emit_b);
            pay_cnt_q <= pay_cnt_q + 16'h0001;
            if (pay_cnt_q + 16'h0001 == wc_q) begin
              state_q <= csvt_pkg::ST_CRC;
            end
          end
        end
        csvt_pkg::ST_CRC: begin
          crc_cnt_q <= 1'b1;
          if (crc_cnt_q) begin
            state_q <= csvt_pkg::ST_TRAIL;
          end
        end
        csvt_pkg::ST_TRAIL: begin
          state_q <= csvt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Lane outputs: bytes of a packet are dealt round-robin over the enabled lanes
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      LANE_BYTE_OUT <= 32'h0;
      LANE_BYTE_VALID_OUT <= 4'h0;
      DATA_LANE_HS_OUT <= 4'h0;
      CLOCK_LANE_HS_OUT <= 1'b0;
      lane_idx_q <= 2'h0;
    end else if (!pin.phy_rst_n) begin
      LANE_BYTE_VALID_OUT <= 4'h0;
      DATA_LANE_HS_OUT <= 4'h0;
      CLOCK_LANE_HS_OUT <= 1'b0;
      lane_idx_q <= 2'h0;
    end else begin
      LANE_BYTE_VALID_OUT <= emit_v ? 4'(4'h1 << lane_idx_q) : 4'h0;
      if (emit_v) begin
        LANE_BYTE_OUT[8*lane_idx_q +: 8] <= emit_b;
        lane_idx_q <= (lane_mask[lane_idx_q + 2'h1] && lane_idx_q != 2'h3) ? lane_idx_q + 2'h1 : 2'h0;
      end else if (state_q == csvt_pkg::ST_TRAIL) begin
        lane_idx_q <= 2'h0;
      end
      DATA_LANE_HS_OUT <= (state_q != csvt_pkg::ST_IDLE) ? (lane_mask & ~ulps_q[3:0]) : 4'h0;
      CLOCK_LANE_HS_OUT <= !ulps_q[4] && (cfg_q.cont_clk || state_q != csvt_pkg::ST_IDLE);
    end
  end

  // Sleep control per lane (index 4 is the clock lane); a request acts only once held long enough
  for (genvar i = 0; i < 5; i++) begin : g_ulps
    logic [15:0] hold_q;
    logic req_q;
    assign conflict_now[i] = pin.sleep[i] & pin.wake[i];
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
        hold_q <= 16'h0000;
        req_q <= 1'b0;
        ulps_q[i] <= 1'b0;
      end else if (!pin.phy_rst_n) begin
        hold_q <= 16'h0000;
        ulps_q[i] <= 1'b0;
      end else begin
        req_q <= pin.sleep[i];
        if (conflict_now[i] || !(pin.sleep[i] ^ pin.wake[i]) || req_q != pin.sleep[i]) begin
          hold_q <= 16'h0000;
        end else if (hold_q != 16'(ULPS_CYCLES)) begin
          hold_q <= hold_q + 16'h0001;
          if (hold_q + 16'h0001 == 16'(ULPS_CYCLES)) begin
            ulps_q[i] <= pin.sleep[i];
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      DATA_LANE_ULPS_OUT <= 4'h0;
      CLOCK_LANE_ULPS_OUT <= 1'b0;
    end else begin
      DATA_LANE_ULPS_OUT <= ulps_q[3:0];
      CLOCK_LANE_ULPS_OUT <= ulps_q[4];
    end
  end

  // Activity monitors for the shared reference clock and the escape clock
  for (genvar k = 0; k < 2; k++) begin : g_alive
    logic prev_q;
    logic [7:0] idle_q;
    logic lvl;
    assign lvl = (k == 0) ? pin.ref_clk : pin.escape_clock;
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
        prev_q <= 1'b0;
        idle_q <= 8'h00;
        alive_q[k] <= 1'b0;
      end else begin
        prev_q <= lvl;
        if (lvl & ~prev_q) begin
          idle_q <= 8'h00;
          alive_q[k] <= 1'b1;
        end else if (idle_q == 8'(ALIVE_CYCLES)) begin
          alive_q[k] <= 1'b0;
        end else begin
          idle_q <= idle_q + 8'h01;
        end
      end
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero
  assign wb_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  assign wb_wr_status = wb_req & WB_WE_IN & WB_SEL_IN[1] & (WB_ADR_IN == `CSVT_ADR_STATUS);

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0;
      ctrl_q <= `CSVT_CTRL_RESET;
    end else begin
      WB_ACK_OUT <= wb_req;
      WB_DAT_OUT <= 32'h0;
      if (wb_req && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == `CSVT_ADR_CTRL) begin
        ctrl_q <= WB_DAT_IN[4:0];
      end
      if (wb_req && !WB_WE_IN) begin
        unique case (WB_ADR_IN)
          `CSVT_ADR_CTRL: WB_DAT_OUT <= {27'h0, ctrl_q};
          `CSVT_ADR_STATUS: WB_DAT_OUT <= {22'h0, drop_q, conflict_q, alive_q[1], alive_q[0], ulps_q,
                                           state_q != csvt_pkg::ST_IDLE};
          `CSVT_ADR_FRAMES: WB_DAT_OUT <= {16'h0, frame_num_q};
          default: WB_DAT_OUT <= 32'h0;
        endcase
      end
    end
  end

  // Sticky error flags; a new event in the clearing cycle survives the clear
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      conflict_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      conflict_q <= (conflict_q & ~(wb_wr_status & WB_DAT_IN[`CSVT_STAT_CONFLICT_BIT])) | (|conflict_now);
      drop_q <= (drop_q & ~(wb_wr_status & WB_DAT_IN[`CSVT_STAT_DROP_BIT]))
                | (pix_tick & pin.valid & in_line_q & (word_bytes_q > 4'h1));
    end
  end

endmodule

// file: csvt_transmitter_props.sv
// Concurrent checks on the transmitter's top-level ports
`timescale 1ns/1ps
module csvt_transmitter_props #(
  parameter int ULPS_CYCLES = 500,
  parameter int ALIVE_CYCLES = 32
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic PHY_RESET_N_IN,
  input wire logic CLOCK_LANE_SLEEP_REQUEST_IN,
  input wire logic CLOCK_LANE_WAKE_REQUEST_IN,
  input wire logic [3:0] DATA_LANE_SLEEP_REQUEST_IN,
  input wire logic [3:0] DATA_LANE_WAKE_REQUEST_IN,
  input wire logic [3:0] LANE_BYTE_VALID_OUT,
  input wire logic [3:0] DATA_LANE_HS_OUT,
  input wire logic CLOCK_LANE_HS_OUT,
  input wire logic CLOCK_LANE_ULPS_OUT,
  input wire logic [3:0] DATA_LANE_ULPS_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  wire req = WB_CYC_IN && WB_STB_IN;
  a_ack_follows_req: assert property (req && !WB_ACK_OUT |=> WB_ACK_OUT) else $error("ack missing");
  a_ack_needs_req: assert property (WB_ACK_OUT |-> $past(req)) else $error("ack without request");
  a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack longer than one cycle");
  a_rdata_idle_zero: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0) else $error("read data outside ack");
  a_byte_one_lane: assert property ($onehot0(LANE_BYTE_VALID_OUT)) else $error("bytes on two lanes");
  a_hs_with_bytes: assert property (|LANE_BYTE_VALID_OUT |->
    CLOCK_LANE_HS_OUT && (DATA_LANE_HS_OUT & LANE_BYTE_VALID_OUT) != 4'h0) else $error("byte outside high speed");
  a_phy_reset_quiet: assert property ((!PHY_RESET_N_IN) [*5] |->
    LANE_BYTE_VALID_OUT == 4'h0 && DATA_LANE_ULPS_OUT == 4'h0 && !CLOCK_LANE_ULPS_OUT) else $error("active in reset");
  // Both requests held together for six cycles or more must leave the state alone for as long as they last
  a_sleep_conflict: assert property ((CLOCK_LANE_SLEEP_REQUEST_IN && CLOCK_LANE_WAKE_REQUEST_IN && PHY_RESET_N_IN) [*6]
    |=> $stable(CLOCK_LANE_ULPS_OUT)) else $error("clock lane moved on conflict");
  a_clock_sleep_cause: assert property ($rose(CLOCK_LANE_ULPS_OUT) |->
    $past(CLOCK_LANE_SLEEP_REQUEST_IN, 4) && !$past(CLOCK_LANE_WAKE_REQUEST_IN, 4)) else $error("clock lane slept");
  a_lane_sleep_cause: assert property ($rose(DATA_LANE_ULPS_OUT[0]) |->
    $past(DATA_LANE_SLEEP_REQUEST_IN[0], 4) && !$past(DATA_LANE_WAKE_REQUEST_IN[0], 4)) else $error("lane slept");
  c_bus_ack: cover property (WB_ACK_OUT);
  c_packet: cover property ($rose(CLOCK_LANE_HS_OUT));
  c_sleep: cover property ($rose(CLOCK_LANE_ULPS_OUT));
endmodule

// file: csvt_rx_model.sv
// Receiver model: presents the byte of whichever data lane is strobed
`timescale 1ns/1ps
module csvt_rx_model (
  input wire logic [31:0] lane_byte_in,
  input wire logic [3:0] lane_valid_in,
  output logic got_out,
  output logic [7:0] byte_out,
  output logic [3:0] lanes_out
);
  // A real receiver cannot push back, so no stall is modelled
  always_comb begin
    got_out = |lane_valid_in;
    lanes_out = lane_valid_in;
    byte_out = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      if (lane_valid_in[i]) begin
        byte_out = lane_byte_in[8*i +: 8];
      end
    end
  end
endmodule

// file: csi2_video_transmitter_tb.sv
// Testbench of the video transmitter: registers, one frame on one lane, lane sleep control
`timescale 1ns/1ps
`include "csvt_params.svh"
module csi2_video_transmitter_tb;
  localparam int ULPS = 20;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdo, rdat, lb;
  logic ref_clk = 1'b0, esc = 1'b0, pclk = 1'b0, phy_rst_n = 1'b0, ctl_rst_n = 1'b0;
  logic vs = 1'b0, hs = 1'b0, pv = 1'b0, cs = 1'b0, cw = 1'b0, chs, cul, got;
  logic [15:0] lw = 16'h0008;
  logic [63:0] pix = 64'h0, seed = 64'h5E;
  logic [5:0] dt = 6'h2A;
  logic [1:0] vc = 2'h1;
  logic [3:0] ds = 4'h0, dw = 4'h0, lv, dhs, dul, rl;
  logic [7:0] rb;
  logic [15:0] crc;
  logic [8:0] exp_q[$];
  int errors = 0;
  int comparisons = 0;

  always #5 clk = ~clk;
  always #40 pclk = ~pclk;
  always #19 ref_clk = ~ref_clk;
  always #25 esc = ~esc;

  csvt_transmitter #(.ULPS_CYCLES(ULPS)) u_csvt_transmitter (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdo), .WB_ACK_OUT(ack), .SHARED_REFERENCE_PIN_IN(ref_clk),
    .PIXEL_CLK_IN(pclk), .ESCAPE_CLOCK_IN(esc), .PHY_RESET_N_IN(phy_rst_n), .CONTROLLER_RESET_N_IN(ctl_rst_n),
    .VSYNC_IN(vs), .HSYNC_IN(hs), .PIXEL_VALID_IN(pv), .LINE_WIDTH_IN(lw), .PIXEL_DATA_IN(pix),
    .DATA_TYPE_IN(dt), .VIRTUAL_CHANNEL_ID_IN(vc), .CLOCK_LANE_SLEEP_REQUEST_IN(cs),
    .CLOCK_LANE_WAKE_REQUEST_IN(cw), .DATA_LANE_SLEEP_REQUEST_IN(ds), .DATA_LANE_WAKE_REQUEST_IN(dw),
    .LANE_BYTE_OUT(lb), .LANE_BYTE_VALID_OUT(lv), .DATA_LANE_HS_OUT(dhs), .CLOCK_LANE_HS_OUT(chs),
    .DATA_LANE_ULPS_OUT(dul), .CLOCK_LANE_ULPS_OUT(cul));

  csvt_rx_model u_csvt_rx_model (.lane_byte_in(lb), .lane_valid_in(lv), .got_out(got), .byte_out(rb), .lanes_out(rl));

  function automatic logic [63:0] xs(input logic [63:0] s);
    s ^= s << 13;
    s ^= s >> 7;
    s ^= s << 17;
    return s;
  endfunction

  // Reflected CRC over one payload word, bits sent low byte first
  function automatic logic [15:0] crc16(input logic [63:0] w);
    logic [15:0] c;
    c = `CSVT_CRC_INIT;
    for (int i = 0; i < 64; i++) c = (c[0] ^ w[i]) ? ((c >> 1) ^ `CSVT_CRC_POLY) : (c >> 1);
    return c;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (ack !== 1'b1) begin
      errors++;
      give_verdict;
    end
    rdat = rdo;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk($sformatf("register %h", a), rdat, e);
  endtask

  // Requests are held past the sleep hold count so the synchroniser delay cannot shorten them
  task automatic hold(input logic a, input logic b, input logic [3:0] c, input logic [3:0] d);
    @(posedge clk);
    {cs, cw, ds, dw} <= {a, b, c, d};
    repeat (ULPS + 10) @(posedge clk);
    {cs, cw, ds, dw} <= 10'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic push(input logic [7:0] di, input logic [15:0] wc);
    exp_q.push_back({1'b0, di});
    exp_q.push_back({1'b0, wc[7:0]});
    exp_q.push_back({1'b0, wc[15:8]});
    exp_q.push_back(9'h100);
  endtask

  always @(posedge clk) begin
    if (got === 1'b1) begin
      chk("lane valid", 32'(rl), 32'h1);
      if (exp_q.size() == 0) chk("spare byte", 32'(rb), 32'h1FF);
      else if (exp_q[0][8]) void'(exp_q.pop_front());
      else chk("lane byte", 32'(rb), 32'(exp_q.pop_front()));
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict;
  end

  initial begin
    int n;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h13);
    rd(8'h40, 32'h0);
    wb(1'b1, 8'h40, 32'hFF, 4'hF);
    wb(1'b1, 8'h00, 32'h10, 4'h1);
    rd(8'h00, 32'h10);
    {phy_rst_n, ctl_rst_n} <= 2'b11;
    repeat (40) @(posedge clk);
    chk("clock lane idle", 32'(chs), 32'h0);
    rd(8'h04, 32'hC0);
    push(8'h40, 16'h1);
    @(posedge pclk);
    vs <= 1'b1;
    repeat (3) @(posedge pclk);
    seed = xs(seed);
    push(8'h6A, 16'h8);
    for (int i = 0; i < 8; i++) exp_q.push_back({1'b0, seed[8*i +: 8]});
    crc = crc16(seed);
    exp_q.push_back({1'b0, crc[7:0]});
    exp_q.push_back({1'b0, crc[15:8]});
    hs <= 1'b1;
    @(posedge pclk);
    {pv, pix} <= {1'b1, seed};
    @(posedge pclk);
    {pv, pix} <= {1'b0, ~seed};
    repeat (2) @(posedge pclk);
    hs <= 1'b0;
    repeat (20) @(posedge pclk);
    push(8'h41, 16'h1);
    vs <= 1'b0;
    for (n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge clk);
    chk("bytes left", 32'(exp_q.size()), 32'h0);
    rd(8'h08, 32'h1);
    ctl_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    ctl_rst_n <= 1'b1;
    rd(8'h08, 32'h0);
    hold(1'b1, 1'b0, 4'hF, 4'h0);
    rd(8'h04, 32'hFE);
    hold(1'b1, 1'b1, 4'h0, 4'h0);
    rd(8'h04, 32'h1FE);
    wb(1'b1, 8'h04, 32'h100, 4'h2);
    rd(8'h04, 32'hFE);
    hold(1'b0, 1'b1, 4'h0, 4'hF);
    rd(8'h04, 32'hC0);
    chk("data lanes awake", 32'(dul), 32'h0);
    hold(1'b1, 1'b0, 4'hF, 4'h0);
    chk("lanes asleep", 32'({cul, dul}), 32'h1F);
    phy_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("sleep after phy reset", 32'({cul, dul}), 32'h0);
    give_verdict;
  end
endmodule

bind csvt_transmitter csvt_transmitter_props #(.ULPS_CYCLES(ULPS_CYCLES), .ALIVE_CYCLES(ALIVE_CYCLES)) u_props (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT),
  .WB_DAT_OUT(WB_DAT_OUT), .PHY_RESET_N_IN(PHY_RESET_N_IN), .CLOCK_LANE_SLEEP_REQUEST_IN(CLOCK_LANE_SLEEP_REQUEST_IN),
  .CLOCK_LANE_WAKE_REQUEST_IN(CLOCK_LANE_WAKE_REQUEST_IN), .DATA_LANE_SLEEP_REQUEST_IN(DATA_LANE_SLEEP_REQUEST_IN),
  .DATA_LANE_WAKE_REQUEST_IN(DATA_LANE_WAKE_REQUEST_IN), .LANE_BYTE_VALID_OUT(LANE_BYTE_VALID_OUT),
  .DATA_LANE_HS_OUT(DATA_LANE_HS_OUT), .CLOCK_LANE_HS_OUT(CLOCK_LANE_HS_OUT),
  .CLOCK_LANE_ULPS_OUT(CLOCK_LANE_ULPS_OUT), .DATA_LANE_ULPS_OUT(DATA_LANE_ULPS_OUT));
